// ===== core/pulse_follower_pkg.sv
// constants, types and helpers shared by the pulse follower design
`default_nettype none

package pulse_follower_pkg;

  // ==========================================================
  // register map, byte addresses on the apb bus
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_GEAR_IN  = 8'h04;
  localparam logic [7:0] OFS_GEAR_OUT = 8'h08;
  localparam logic [7:0] OFS_KP       = 8'h0c;
  localparam logic [7:0] OFS_CMD_POS  = 8'h10;
  localparam logic [7:0] OFS_FB_POS   = 8'h14;
  localparam logic [7:0] OFS_POS_ERR  = 8'h18;
  localparam logic [7:0] OFS_VEL_CMD  = 8'h1c;

  // ==========================================================
  // field layouts and enumerations
  typedef enum logic [1:0] {
    MODE_STEP_DIR = 2'b00,
    MODE_QUAD     = 2'b01,
    MODE_CW_CCW   = 2'b10
  } follow_mode_e;

  typedef enum logic [1:0] {
    SRC_SCHMITT = 2'b00,
    SRC_OPTO    = 2'b01,
    SRC_DIFF    = 2'b10
  } input_src_e;

  // control word, bit 0 = enable, bit 6 = zero (self clearing)
  typedef struct packed {
    logic         zero_pos;
    input_src_e   src;
    logic         reverse;
    follow_mode_e mode;
    logic         enable;
  } ctrl_s;

  // command pins, one step and one direction per receiver type
  typedef struct packed {
    logic step_se;
    logic dir_se;
    logic step_opto;
    logic dir_opto;
    logic step_diff;
    logic dir_diff;
  } cmd_pins_s;

  localparam int unsigned CTRL_W = 7;
  localparam int unsigned PINS_W = 6;

  // ==========================================================
  // values after reset
  localparam ctrl_s       CTRL_RST     = 7'h00;
  localparam logic [15:0] GEAR_IN_RST  = 16'h0001;
  localparam logic [15:0] GEAR_OUT_RST = 16'h0001;
  localparam logic [15:0] KP_RST       = 16'h0040;

  // ==========================================================
  // clamp a gain product to the signed 32-bit range
  function automatic logic signed [31:0] sat32(
    input logic signed [48:0] v
  );
    logic signed [31:0] r;
    r = v[31:0];
    if (v > 49'sh0_0000_7fff_ffff)
      r = 32'sh7fff_ffff;
    else if (v < -49'sh0_0000_8000_0000)
      r = 32'sh8000_0000;
    return r;
  endfunction

endpackage

`default_nettype wire

// ===== core/pin_sync.sv
// two flip-flop synchroniser for a vector of asynchronous pins
`default_nettype none

module pin_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         pclk,    // system clock
  input  wire logic         presetn, // async reset, active low
  input  wire logic [W-1:0] d,       // raw pin levels
  output logic      [W-1:0] q        // synchronised levels
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;

  // ==========================================================
  // first stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_q <= '0;
      s2_q <= '0;
    end
    else
    begin
      s1_q <= d;
      s2_q <= s1_q;
    end
  end

  assign q = s2_q;

endmodule

`default_nettype wire

// ===== core/quad_decode.sv
// quadrature a/b decoder giving one up or down pulse per edge
`default_nettype none

module quad_decode (
  input  wire logic pclk,    // system clock
  input  wire logic presetn, // async reset, active low
  input  wire logic a,       // synchronised phase a
  input  wire logic b,       // synchronised phase b
  output logic      up,      // one cycle pulse, forward edge
  output logic      dn       // one cycle pulse, backward edge
);

  logic a_q;
  logic b_q;
  logic chg;

  // ==========================================================
  // previous phase levels
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      a_q <= 1'b0;
      b_q <= 1'b0;
    end
    else
    begin
      a_q <= a;
      b_q <= b;
    end
  end

  // single phase change counts, double change is dropped
  assign chg = (a ^ a_q) ^ (b ^ b_q);
  assign up  = chg & (a_q ^ b);
  assign dn  = chg & ~(a_q ^ b);

endmodule

`default_nettype wire

// ===== core/pulse_follower.sv
// pulse follower command counter with apb registers
`default_nettype none

module pulse_follower (
  input  wire logic                          pclk,     // 125 mhz clock
  input  wire logic                          presetn,  // async reset, low
  input  wire logic                          psel,     // apb select
  input  wire logic                          penable,  // apb access phase
  input  wire logic                          pwrite,   // apb write
  input  wire logic [7:0]                    paddr,    // apb byte address
  input  wire logic [31:0]                   pwdata,   // apb write data
  output logic      [31:0]                   prdata,   // apb read data
  output logic                               pready,   // apb ready
  output logic                               pslverr,  // apb error
  input  wire pulse_follower_pkg::cmd_pins_s cmd_pins, // command pins
  input  wire logic                          fb_a,     // feedback phase a
  input  wire logic                          fb_b,     // feedback phase b
  output logic      [31:0]                   pos_err,  // command - feedback
  output logic      [31:0]                   vel_cmd   // velocity command
);
  import pulse_follower_pkg::*;

  logic [PINS_W+1:0]  sync_out;
  cmd_pins_s          pins_s;
  logic               fa_s;
  logic               fb_s;
  ctrl_s              ctrl_q;
  logic [15:0]        gear_in_q;
  logic [15:0]        gear_out_q;
  logic [15:0]        kp_q;
  logic               pready_q;
  logic               pslverr_q;
  logic [31:0]        prdata_q;
  logic [31:0]        rdata_d;
  logic               rmiss_d;
  logic               wr_done;
  logic               sel_step;
  logic               sel_dir;
  logic               step_prev_q;
  logic               dir_prev_q;
  logic               rise_step;
  logic               rise_ccw;
  logic               cq_up;
  logic               cq_dn;
  logic               fq_up;
  logic               fq_dn;
  logic               ev_d;
  logic               up_raw;
  logic               ev_q;
  logic               ev_up_q;
  logic signed [39:0] pend_q;
  logic signed [39:0] gi40;
  logic signed [39:0] go40;
  logic               fwd;
  logic               back;
  logic signed [31:0] cmd_q;
  logic signed [31:0] fb_q;
  logic signed [31:0] err_q;
  logic signed [31:0] vel_q;
  logic signed [48:0] prod;

  // ==========================================================
  // input synchronisers and quadrature decoders
  pin_sync #(.W(PINS_W + 2)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({cmd_pins, fb_a, fb_b}),
    .q       (sync_out)
  );

  assign pins_s = sync_out[PINS_W+1:2];
  assign fa_s   = sync_out[1];
  assign fb_s   = sync_out[0];

  // command quadrature only from the differential receivers
  quad_decode u_cmd_quad (
    .pclk    (pclk),
    .presetn (presetn),
    .a       (pins_s.step_diff),
    .b       (pins_s.dir_diff),
    .up      (cq_up),
    .dn      (cq_dn)
  );

  quad_decode u_fb_quad (
    .pclk    (pclk),
    .presetn (presetn),
    .a       (fa_s),
    .b       (fb_s),
    .up      (fq_up),
    .dn      (fq_dn)
  );

  // ==========================================================
  // apb slave, one wait state on every transfer
  assign wr_done = psel & penable & pready_q & pwrite;

  // read mux and unmapped address decode
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    rmiss_d = 1'b0;
    case (paddr)
      OFS_CTRL:     rdata_d = {25'h0000000, ctrl_q};
      OFS_GEAR_IN:  rdata_d = {16'h0000, gear_in_q};
      OFS_GEAR_OUT: rdata_d = {16'h0000, gear_out_q};
      OFS_KP:       rdata_d = {16'h0000, kp_q};
      OFS_CMD_POS:  rdata_d = cmd_q;
      OFS_FB_POS:   rdata_d = fb_q;
      OFS_POS_ERR:  rdata_d = err_q;
      OFS_VEL_CMD:  rdata_d = vel_q;
      default:      rmiss_d = 1'b1;
    endcase
  end

  // ready, error and read data handshake
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
    else
    begin
      pready_q  <= psel & penable & ~pready_q;
      pslverr_q <= psel & penable & ~pready_q & rmiss_d;
      if (psel & penable & ~pready_q & ~pwrite)
        prdata_q <= rdata_d;
    end
  end

  // writable registers, values act on the next cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q     <= CTRL_RST;
      gear_in_q  <= GEAR_IN_RST;
      gear_out_q <= GEAR_OUT_RST;
      kp_q       <= KP_RST;
    end
    else
    begin
      ctrl_q.zero_pos <= 1'b0;
      if (wr_done && paddr == OFS_CTRL)
        ctrl_q <= pwdata[CTRL_W-1:0];
      if (wr_done && paddr == OFS_GEAR_IN)
        gear_in_q <= pwdata[15:0];
      if (wr_done && paddr == OFS_GEAR_OUT)
        gear_out_q <= pwdata[15:0];
      if (wr_done && paddr == OFS_KP)
        kp_q <= pwdata[15:0];
    end
  end

  // ==========================================================
  // command source select and edge detection
  always_comb
  begin
    case (ctrl_q.src)
      SRC_SCHMITT:
      begin
        sel_step = pins_s.step_se;
        sel_dir  = pins_s.dir_se;
      end
      SRC_OPTO:
      begin
        sel_step = pins_s.step_opto;
        sel_dir  = pins_s.dir_opto;
      end
      default:
      begin
        sel_step = pins_s.step_diff;
        sel_dir  = pins_s.dir_diff;
      end
    endcase
  end

  // previous levels for rising edge detection
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      step_prev_q <= 1'b0;
      dir_prev_q  <= 1'b0;
    end
    else
    begin
      step_prev_q <= sel_step;
      dir_prev_q  <= sel_dir;
    end
  end

  assign rise_step = sel_step & ~step_prev_q;
  assign rise_ccw  = sel_dir & ~dir_prev_q;

  // one signed command event per decoded edge
  always_comb
  begin
    ev_d   = 1'b0;
    up_raw = 1'b0;
    if (ctrl_q.enable)
    begin
      case (ctrl_q.mode)
        MODE_STEP_DIR:
        begin
          ev_d   = rise_step;
          up_raw = sel_dir;
        end
        MODE_QUAD:
        begin
          ev_d   = cq_up | cq_dn;
          up_raw = cq_up;
        end
        MODE_CW_CCW:
        begin
          ev_d   = rise_step ^ rise_ccw;
          up_raw = rise_step;
        end
        default:
        begin
          ev_d   = 1'b0;
          up_raw = 1'b0;
        end
      endcase
    end
  end

  // event register with reverse applied
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ev_q    <= 1'b0;
      ev_up_q <= 1'b0;
    end
    else
    begin
      ev_q    <= ev_d;
      ev_up_q <= up_raw ^ ctrl_q.reverse;
    end
  end

  // ==========================================================
  // electronic gear: pending numerator drained one count a cycle
  assign gi40 = {24'h000000, gear_in_q};
  assign go40 = {24'h000000, gear_out_q};
  assign fwd  = (gear_in_q != 16'h0000) && (pend_q >= gi40);
  assign back = (gear_in_q != 16'h0000) && (pend_q <= -gi40);

  // remainder stays in the pending count between pulses
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pend_q <= 40'sh00_0000_0000;
    else if (ctrl_q.zero_pos)
      pend_q <= 40'sh00_0000_0000;
    else
      pend_q <= pend_q
              + (ev_q ? (ev_up_q ? go40 : -go40) : 40'sh00_0000_0000)
              - (fwd ? gi40 : 40'sh00_0000_0000)
              + (back ? gi40 : 40'sh00_0000_0000);
  end

  // 32-bit command position counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cmd_q <= 32'sh0000_0000;
    else if (ctrl_q.zero_pos)
      cmd_q <= 32'sh0000_0000;
    else if (fwd)
      cmd_q <= cmd_q + 32'sh0000_0001;
    else if (back)
      cmd_q <= cmd_q - 32'sh0000_0001;
  end

  // 32-bit feedback position counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fb_q <= 32'sh0000_0000;
    else if (ctrl_q.zero_pos)
      fb_q <= 32'sh0000_0000;
    else if (fq_up)
      fb_q <= fb_q + 32'sh0000_0001;
    else if (fq_dn)
      fb_q <= fb_q - 32'sh0000_0001;
  end

  // ==========================================================
  // position error and proportional velocity command
  assign prod = err_q * $signed({1'b0, kp_q});

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      err_q <= 32'sh0000_0000;
      vel_q <= 32'sh0000_0000;
    end
    else
    begin
      err_q <= cmd_q - fb_q;
      vel_q <= sat32(prod);
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign pos_err = err_q;
  assign vel_cmd = vel_q;

  // ==========================================================
  // checks
  property p_step_dir;
    @(posedge pclk) disable iff (!presetn)
    (ctrl_q.enable && ctrl_q.mode == MODE_STEP_DIR && rise_step)
      |=> (ev_q && ev_up_q == ($past(sel_dir) ^ $past(ctrl_q.reverse)));
  endproperty
  a_step_dir: assert property (p_step_dir)
    else $error("step edge not turned into a signed event");

  property p_no_step;
    @(posedge pclk) disable iff (!presetn)
    (ctrl_q.mode == MODE_STEP_DIR && !rise_step) |=> !ev_q;
  endproperty
  a_no_step: assert property (p_no_step)
    else $error("event without a step edge");

  property p_cw_ccw;
    @(posedge pclk) disable iff (!presetn)
    (ctrl_q.enable && ctrl_q.mode == MODE_CW_CCW && rise_ccw && !rise_step)
      |=> (ev_q && ev_up_q == $past(ctrl_q.reverse));
  endproperty
  a_cw_ccw: assert property (p_cw_ccw)
    else $error("ccw pulse did not move backward");

  property p_quad;
    @(posedge pclk) disable iff (!presetn)
    (ctrl_q.enable && ctrl_q.mode == MODE_QUAD)
      |=> (ev_q == ($past(cq_up) || $past(cq_dn)));
  endproperty
  a_quad: assert property (p_quad)
    else $error("quadrature command edge miscounted");

  property p_gear_step;
    @(posedge pclk) disable iff (!presetn)
    (!ctrl_q.zero_pos && gear_in_q != 16'h0000 && pend_q >= gi40)
      |=> (cmd_q == $past(cmd_q) + 32'sh0000_0001);
  endproperty
  a_gear_step: assert property (p_gear_step)
    else $error("command counter did not advance on gear overflow");

  property p_gear_hold;
    @(posedge pclk) disable iff (!presetn)
    (!ctrl_q.zero_pos && !ev_q && !fwd && !back) |=> $stable(pend_q);
  endproperty
  a_gear_hold: assert property (p_gear_hold)
    else $error("gear remainder changed without cause");

  property p_gear_write;
    @(posedge pclk) disable iff (!presetn)
    (wr_done && paddr == OFS_GEAR_OUT)
      |=> (gear_out_q == $past(pwdata[15:0]));
  endproperty
  a_gear_write: assert property (p_gear_write)
    else $error("gear output value not applied at once");

  property p_err;
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> (err_q == $past(cmd_q) - $past(fb_q));
  endproperty
  a_err: assert property (p_err)
    else $error("position error not command minus feedback");

  property p_vel;
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> (vel_q == sat32($past(err_q) * $signed({1'b0,
              $past(kp_q)})));
  endproperty
  a_vel: assert property (p_vel)
    else $error("velocity command not error times gain");

  property p_apb_wait;
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable) ##1 (psel && penable) |=> pready_q;
  endproperty
  a_apb_wait: assert property (p_apb_wait)
    else $error("apb transfer not answered after one wait state");

endmodule

`default_nettype wire

// ===== sim/cmd_source.sv
// command and feedback source model: step/dir, quadrature and cw/ccw
`default_nettype none

module cmd_source (
  input  wire logic                         pclk, // system clock
  output var  pulse_follower_pkg::cmd_pins_s pins, // command pin levels
  output logic                              fb_a, // feedback phase a
  output logic                              fb_b  // feedback phase b
);
  timeunit 1ns;
  timeprecision 1ps;
  import pulse_follower_pkg::*;

  logic [5:0] p_q;  // msb step_se .. lsb dir_diff
  logic [1:0] c_ph; // command quadrature phase
  logic [1:0] f_ph; // feedback quadrature phase

  assign pins = p_q;

  // ==========================================================
  // idle levels
  initial
  begin
    p_q  = 6'h00;
    c_ph = 2'h0;
    f_ph = 2'h0;
    fb_a = 1'b0;
    fb_b = 1'b0;
  end

  // each level stays well past the two synchroniser stages
  task automatic hold();
    repeat (4) @(posedge pclk);
  endtask

  // n rising edges on one pin, low between them
  task automatic pulse(input int idx, input int n);
    repeat (n)
    begin
      p_q[idx] <= 1'b1;
      hold();
      p_q[idx] <= 1'b0;
      hold();
    end
  endtask

  // direction level set first, then the step pulses, then released
  task automatic step(input int s, input logic dir, input int n);
    p_q[4-2*s] <= dir;
    hold();
    pulse(5 - 2 * s, n);
    p_q[4-2*s] <= 1'b0;
    hold();
  endtask

  // step pin carries cw, direction pin carries ccw
  task automatic cwccw(input int s, input logic ccw, input int n);
    pulse(ccw ? 4 - 2 * s : 5 - 2 * s, n);
  endtask

  // n gray transitions, b leading a when n is positive (decoder up)
  task automatic quad(input int ai, input int bi, input int n,
                      input bit fb);
    logic [1:0] d;
    d = (n < 0) ? 2'h1 : 2'h3;
    repeat ((n < 0) ? -n : n)
    begin
      if (fb)
      begin
        f_ph = f_ph + d;
        fb_a <= f_ph[0] ^ f_ph[1];
        fb_b <= f_ph[1];
      end
      else
      begin
        c_ph = c_ph + d;
        p_q[ai] <= c_ph[0] ^ c_ph[1];
        p_q[bi] <= c_ph[1];
      end
      hold();
    end
  endtask
endmodule

`default_nettype wire

// ===== sim/tb_pulse_follower.sv
// self-checking testbench for the pulse follower command counter
`default_nettype none

module tb_pulse_follower;
  timeunit 1ns;
  timeprecision 1ps;
  import pulse_follower_pkg::*;

  logic        pclk;      // system clock
  logic        presetn;   // reset, active low
  logic        psel;      // apb select
  logic        penable;   // apb access phase
  logic        pwrite;    // apb write
  logic [7:0]  paddr;     // apb address
  logic [31:0] pwdata;    // apb write data
  logic [31:0] prdata;    // apb read data
  logic        pready;    // apb ready
  logic        pslverr;   // apb error
  cmd_pins_s   cmd_pins;  // command pins
  logic        fb_a;      // feedback phase a
  logic        fb_b;      // feedback phase b
  logic [31:0] pos_err;   // position difference
  logic [31:0] vel_cmd;   // velocity command
  int          err_count; // mismatches
  int          n_checks;  // comparisons
  int          cyc;       // cycles run
  logic [7:0]  ofs [8] = '{OFS_CTRL, OFS_GEAR_IN, OFS_GEAR_OUT, OFS_KP,
                           OFS_CMD_POS, OFS_FB_POS, OFS_POS_ERR,
                           OFS_VEL_CMD};
  logic [31:0] rst [8] = '{32'h0, 32'h1, 32'h1, 32'h40, 32'h0, 32'h0,
                           32'h0, 32'h0};

  pulse_follower i_pulse_follower (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmd_pins(cmd_pins), .fb_a(fb_a), .fb_b(fb_b),
    .pos_err(pos_err), .vel_cmd(vel_cmd));

  cmd_source i_cmd_source (.pclk(pclk), .pins(cmd_pins), .fb_a(fb_a),
    .fb_b(fb_b));

  // ==========================================================
  // clock and hang guard
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      results();
    end
  end

  // ==========================================================
  // checking and bus tasks
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // pready high ends this wait, or else the cycle ceiling
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, a, d, rd, er);
    chk($sformatf("write error %h", a), 32'h0, {31'h0, er});
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                        input logic exp_er);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, a, 32'h0, rd, er);
    chk($sformatf("read data %h", a), exp, rd);
    chk($sformatf("read error %h", a), {31'h0, exp_er}, {31'h0, er});
  endtask

  // clear counters while disabled, set gears, then enable
  task automatic cfg(input logic [1:0] md, input logic rev,
                     input logic [1:0] src, input logic [15:0] gi,
                     input logic [15:0] go);
    wr(OFS_CTRL, 32'h40);
    wr(OFS_GEAR_IN, {16'h0, gi});
    wr(OFS_GEAR_OUT, {16'h0, go});
    wr(OFS_CTRL, {26'h0, src, rev, md, 1'b1});
  endtask

  task automatic settle();
    repeat (120) @(posedge pclk);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================================
  // test sequence
  initial
  begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, refusals, read-only and narrow registers
    foreach (ofs[i]) rd_chk(ofs[i], rst[i], 1'b0);
    rd_chk(8'h20, 32'h0, 1'b1);
    rd_chk(8'h02, 32'h0, 1'b1);
    wr(OFS_CMD_POS, 32'h1234);
    rd_chk(OFS_CMD_POS, 32'h0, 1'b0);
    wr(OFS_GEAR_IN, 32'hffff_ffff);
    rd_chk(OFS_GEAR_IN, 32'h0000_ffff, 1'b0);
    // one step gives one hundred counts, each way
    cfg(2'h0, 1'b0, 2'h2, 16'h1, 16'h64);
    i_cmd_source.step(2, 1'b1, 1);
    settle();
    rd_chk(OFS_CMD_POS, 32'h64, 1'b0);
    i_cmd_source.step(2, 1'b0, 1);
    settle();
    rd_chk(OFS_CMD_POS, 32'h0, 1'b0);
    // every receiver type, plain then reversed, and cw/ccw
    for (int s = 0; s < 3; s++)
    begin
      cfg(2'h0, 1'b0, s[1:0], 16'h1, 16'h1);
      i_cmd_source.step(s, 1'b1, 3);
      settle();
      rd_chk(OFS_CMD_POS, 32'h3, 1'b0);
      cfg(2'h0, 1'b1, s[1:0], 16'h1, 16'h1);
      i_cmd_source.step(s, 1'b1, 2);
      settle();
      rd_chk(OFS_CMD_POS, 32'hffff_fffe, 1'b0);
      cfg(2'h2, 1'b0, s[1:0], 16'h1, 16'h1);
      i_cmd_source.cwccw(s, 1'b0, 3);
      i_cmd_source.cwccw(s, 1'b1, 1);
      settle();
      rd_chk(OFS_CMD_POS, 32'h2, 1'b0);
    end
    // quadrature: differential only, both signs, reverse with gear
    cfg(2'h1, 1'b0, 2'h0, 16'h1, 16'h1);
    i_cmd_source.quad(1, 0, 8, 1'b0);
    settle();
    rd_chk(OFS_CMD_POS, 32'h8, 1'b0);
    i_cmd_source.quad(5, 4, 8, 1'b0);
    settle();
    rd_chk(OFS_CMD_POS, 32'h8, 1'b0);
    i_cmd_source.quad(1, 0, -12, 1'b0);
    settle();
    rd_chk(OFS_CMD_POS, 32'hffff_fffc, 1'b0);
    cfg(2'h1, 1'b1, 2'h0, 16'h2, 16'h5);
    i_cmd_source.quad(1, 0, 8, 1'b0);
    settle();
    rd_chk(OFS_CMD_POS, 32'hffff_ffec, 1'b0);
    // gear 3 in, 2 out keeps the remainder between steps
    cfg(2'h0, 1'b0, 2'h2, 16'h3, 16'h2);
    for (int i = 1; i <= 3; i++)
    begin
      i_cmd_source.step(2, 1'b1, 1);
      settle();
      rd_chk(OFS_CMD_POS, 32'((2 * i) / 3), 1'b0);
    end
    // new gear acts on the next step with no restart
    cfg(2'h0, 1'b0, 2'h2, 16'h1, 16'h1);
    i_cmd_source.step(2, 1'b1, 1);
    wr(OFS_CTRL, 32'h20);
    wr(OFS_GEAR_OUT, 32'h7);
    wr(OFS_CTRL, 32'h21);
    i_cmd_source.step(2, 1'b1, 1);
    settle();
    rd_chk(OFS_CMD_POS, 32'h8, 1'b0);
    // no decoding selected, then following disabled
    cfg(2'h3, 1'b0, 2'h2, 16'h1, 16'h1);
    i_cmd_source.step(2, 1'b1, 2);
    wr(OFS_CTRL, 32'h20);
    i_cmd_source.step(2, 1'b1, 2);
    settle();
    rd_chk(OFS_CMD_POS, 32'h0, 1'b0);
    // feedback against command, error and gain
    cfg(2'h0, 1'b0, 2'h2, 16'h1, 16'h1);
    i_cmd_source.step(2, 1'b1, 3);
    i_cmd_source.quad(0, 0, 8, 1'b1);
    settle();
    rd_chk(OFS_FB_POS, 32'h8, 1'b0);
    rd_chk(OFS_POS_ERR, 32'hffff_fffb, 1'b0);
    rd_chk(OFS_VEL_CMD, 32'hffff_fec0, 1'b0);
    chk("pos_err port", 32'hffff_fffb, pos_err);
    chk("vel_cmd port", 32'hffff_fec0, vel_cmd);
    // narrow gain register: only the low half is kept
    wr(OFS_KP, 32'h0001_0003);
    rd_chk(OFS_VEL_CMD, 32'hffff_fff1, 1'b0);
    results();
  end
endmodule

`default_nettype wire
